//--- design/cgpl_div_if.sv
// connection between the loop control and one modulo edge divider
`timescale 1ns/100ps
interface cgpl_div_if #(parameter int W = cgpl_pkg::CNT_W);
   logic         in_tick;
   logic [W-1:0] modulus;
   logic         out_tick;
   modport src (output in_tick, output modulus, input out_tick);
   modport div (input in_tick, input modulus, output out_tick);
endinterface

//--- design/cgpl_loop_ctrl.sv
// loop divider, phase and lock detection and filter mode control
`timescale 1ns/100ps
// Function
// - centre frequency is linear factor times two to exponent times 125 kHz.
// - vco span runs from half to double the centre frequency.
// - reference input is divided by modulo factor R into divided reference.
// - vco passes a 2^P prescaler then modulo N to form feedback.
// - phase detector pulses up or down by phase difference of both clocks.
// - lock detector compares frequencies per reference period, sets mode and lock.
// - acquisition makes large corrections; tracking select reads clear.
// - tracking applies when not acquiring or when tracking select is set.
// - automatic bandwidth lets the lock detector switch modes itself.
// - automatic mode: tracking select read-only, set inside tolerance.
// - automatic mode: settled read-only, set inside tolerance, cleared outside.
// - automatic mode with enable set: interrupt on every settled toggle.
// - manual mode: tracking select is written directly to choose mode.
// - manual mode: settled indication disabled, no interrupts raised.
// - manual mode: change flag and settled read zero.
// - manual mode: interrupt enable forced zero, writes ignored.
module cgpl_loop_ctrl #(
   parameter int LOCK_PERIODS = cgpl_pkg::LOCK_PERIODS
) (
   input  wire logic                            ref_clk,
   input  wire logic                            sys_rst,
   input  wire logic                            buffered_ref_clock,
   input  wire logic                            vco_clock,
   input  wire logic                            loop_power_en,
   input  wire logic                            auto_bw,
   input  wire logic                            tracking_select_wr,
   input  wire logic                            settle_change_irq_en_wr,
   input  wire logic                            flag_clear,
   input  wire logic                            base_source_sel,
   input  wire logic [cgpl_pkg::REF_DIV_W-1:0]  ref_div_r,
   input  wire logic [cgpl_pkg::FB_MOD_W-1:0]   fb_mod_n,
   input  wire logic [cgpl_pkg::EXP_W-1:0]      prescale_p,
   input  wire logic [cgpl_pkg::EXP_W-1:0]      range_e,
   input  wire logic [cgpl_pkg::LIN_W-1:0]      linear_l,
   output logic                                 divided_ref_clock,
   output logic                                 prescaled_vco_clock,
   output logic                                 feedback_clock,
   output logic                                 pump_up,
   output logic                                 pump_dn,
   output logic                                 filter_tracking,
   output logic                                 tracking_select,
   output logic                                 settled,
   output logic                                 settle_change_flag,
   output logic                                 settle_change_irq_en,
   output logic                                 irq,
   output logic                                 base_source_eff,
   output logic [cgpl_pkg::KHZ_W-1:0]           centre_freq_khz,
   output logic [cgpl_pkg::KHZ_W-1:0]           vco_min_khz,
   output logic [cgpl_pkg::KHZ_W-1:0]           vco_max_khz
);
   localparam int KW = cgpl_pkg::KHZ_W;
   localparam int RW = cgpl_pkg::RUN_W;
   localparam logic [RW-1:0] LOCK_RUN = RW'(LOCK_PERIODS);

   if (LOCK_PERIODS < 1 || LOCK_PERIODS > 15) begin : g_chk
      $error("cgpl_loop_ctrl: LOCK_PERIODS out of range");
   end

   function automatic logic [KW-1:0] centre_khz(input logic [cgpl_pkg::LIN_W-1:0] l,
                                               input logic [cgpl_pkg::EXP_W-1:0] e);
      logic [KW-1:0] t;
      t = KW'(l) << e;
      return KW'(t * cgpl_pkg::NOM_KHZ_V);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] s1, s2, s3, pin_state, next_pin_state;
   logic       ref_rise, vco_rise;

   always_comb begin
      next_pin_state = pin_state;
      for (int i = 0; i < 2; i++) begin
         if (s2[i] == s3[i]) begin
            next_pin_state[i] = s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s1        <= '0;
         s2        <= '0;
         s3        <= '0;
         pin_state <= '0;
      end else begin
         s1        <= {vco_clock, buffered_ref_clock};
         s2        <= s1;
         s3        <= s2;
         pin_state <= next_pin_state;
      end
   end

   assign ref_rise = next_pin_state[0] & ~pin_state[0];
   assign vco_rise = next_pin_state[1] & ~pin_state[1];

   // ---------------------------------------------------------------
   // dividers
   // ---------------------------------------------------------------
   logic loop_active;
   // a zero linear factor keeps the loop off
   assign loop_active = loop_power_en && (linear_l != '0);

   cgpl_div_if #(.W(cgpl_pkg::CNT_W)) ref_if ();
   cgpl_div_if #(.W(cgpl_pkg::CNT_W)) pre_if ();
   cgpl_div_if #(.W(cgpl_pkg::CNT_W)) fb_if  ();

   assign ref_if.in_tick = ref_rise;
   assign ref_if.modulus = cgpl_pkg::CNT_W'(ref_div_r);
   assign pre_if.in_tick = vco_rise;
   assign pre_if.modulus = cgpl_pkg::CNT_W'(1) << prescale_p;
   assign fb_if.in_tick  = pre_if.out_tick;
   assign fb_if.modulus  = fb_mod_n;

   cgpl_mod_div #(.W(cgpl_pkg::CNT_W)) u_ref_div (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .enable  (loop_active),
      .d       (ref_if)
   );
   cgpl_mod_div #(.W(cgpl_pkg::CNT_W)) u_pre_div (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .enable  (loop_active),
      .d       (pre_if)
   );
   cgpl_mod_div #(.W(cgpl_pkg::CNT_W)) u_fb_div (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .enable  (loop_active),
      .d       (fb_if)
   );

   logic ref_tick, fb_tick;
   assign ref_tick = ref_if.out_tick;
   assign fb_tick  = fb_if.out_tick;

   // ---------------------------------------------------------------
   // detectors and filter mode
   // ---------------------------------------------------------------
   logic          next_divided_ref_clock, next_prescaled_vco_clock, next_feedback_clock;
   logic          next_up, next_dn, next_tracking, next_settled, next_flag;
   logic          next_irq, next_base, settled_prev, next_settled_prev;
   logic [1:0]    fb_cnt, next_fb_cnt;
   logic [RW-1:0] run, next_run;
   logic          in_tol, next_in_tol, flag;
   logic [KW-1:0] next_centre;
   logic [2:0]    seen;

   always_comb begin
      next_divided_ref_clock   = divided_ref_clock ^ ref_tick;
      next_prescaled_vco_clock = prescaled_vco_clock ^ pre_if.out_tick;
      next_feedback_clock      = feedback_clock ^ fb_tick;
      // tri-state phase detector: both pending cancels
      next_up = pump_up | ref_tick;
      next_dn = pump_dn | fb_tick;
      if (next_up && next_dn) begin
         next_up = 1'b0;
         next_dn = 1'b0;
      end
      // frequency comparison: exactly one feedback edge per reference period
      seen        = 3'(fb_cnt) + 3'(fb_tick);
      next_fb_cnt = fb_cnt;
      next_run    = run;
      next_in_tol = in_tol;
      if (ref_tick) begin
         next_fb_cnt = '0;
         if (seen == 3'h1) begin
            if (run < LOCK_RUN) begin
               next_run = RW'(run + RW'(1));
            end
            next_in_tol = (next_run >= LOCK_RUN);
         end else begin
            next_run    = '0;
            next_in_tol = 1'b0;
         end
      end else if (fb_tick && fb_cnt != 2'h3) begin
         next_fb_cnt = 2'(fb_cnt + 2'h1);
      end
      // auto: detector picks mode; manual: written bit picks it
      next_tracking = auto_bw ? next_in_tol : tracking_select_wr;
      next_settled  = auto_bw & next_in_tol;
      next_settled_prev = settled;
      // a toggle in the same cycle as a clear keeps the flag set
      next_flag = auto_bw & ((settled != settled_prev) | (flag & ~flag_clear));
      next_irq  = next_flag & auto_bw & settle_change_irq_en_wr;
      next_base = base_source_sel & loop_active;
      if (!loop_active) begin
         next_up       = 1'b0;
         next_dn       = 1'b0;
         next_fb_cnt   = '0;
         next_run      = '0;
         next_in_tol   = 1'b0;
         next_tracking = 1'b0;
         next_settled  = 1'b0;
      end
      next_centre = centre_khz(linear_l, range_e);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         divided_ref_clock   <= 1'b0;
         prescaled_vco_clock <= 1'b0;
         feedback_clock      <= 1'b0;
         pump_up             <= 1'b0;
         pump_dn             <= 1'b0;
         fb_cnt              <= '0;
         run                 <= '0;
         in_tol              <= 1'b0;
         filter_tracking     <= 1'b0;
         settled             <= 1'b0;
         settled_prev        <= 1'b0;
         flag                <= 1'b0;
         irq                 <= 1'b0;
         base_source_eff     <= 1'b0;
         centre_freq_khz     <= '0;
         vco_min_khz         <= '0;
         vco_max_khz         <= '0;
      end else begin
         divided_ref_clock   <= next_divided_ref_clock;
         prescaled_vco_clock <= next_prescaled_vco_clock;
         feedback_clock      <= next_feedback_clock;
         pump_up             <= next_up;
         pump_dn             <= next_dn;
         fb_cnt              <= next_fb_cnt;
         run                 <= next_run;
         in_tol              <= next_in_tol;
         filter_tracking     <= next_tracking;
         settled             <= next_settled;
         settled_prev        <= next_settled_prev;
         flag                <= next_flag;
         irq                 <= next_irq;
         base_source_eff     <= next_base;
         centre_freq_khz     <= next_centre;
         vco_min_khz         <= next_centre >> 1;
         vco_max_khz         <= KW'(next_centre << 1);
      end
   end

   assign tracking_select      = filter_tracking;
   assign settle_change_flag   = flag & auto_bw;
   assign settle_change_irq_en = settle_change_irq_en_wr & auto_bw;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_pfd_excl;
      @(posedge ref_clk) disable iff (sys_rst)
      !(pump_up && pump_dn);
   endproperty
   a_pfd_excl: assert property (p_pfd_excl) else $error("both pump pulses active");

   property p_off_acq;
      @(posedge ref_clk) disable iff (sys_rst)
      !loop_power_en |=> !filter_tracking && !settled && !pump_up && !pump_dn;
   endproperty
   a_off_acq: assert property (p_off_acq) else $error("loop off but not acquiring");

   property p_manual_mode;
      @(posedge ref_clk) disable iff (sys_rst)
      (!auto_bw && loop_active) |=> (filter_tracking == $past(tracking_select_wr));
   endproperty
   a_manual_mode: assert property (p_manual_mode) else $error("manual mode not followed");

   property p_auto_track;
      @(posedge ref_clk) disable iff (sys_rst)
      (auto_bw && loop_active) |=> (filter_tracking == settled);
   endproperty
   a_auto_track: assert property (p_auto_track) else $error("auto mode differs from settled");

   property p_toggle_irq;
      @(posedge ref_clk) disable iff (sys_rst)
      (auto_bw && settle_change_irq_en_wr && settled != $past(settled)) |=> irq;
   endproperty
   a_toggle_irq: assert property (p_toggle_irq) else $error("settle toggle raised no irq");

   property p_manual_quiet;
      @(posedge ref_clk) disable iff (sys_rst)
      (!auto_bw && $past(!auto_bw)) |-> !settled && !settle_change_flag && !irq;
   endproperty
   a_manual_quiet: assert property (p_manual_quiet) else $error("manual mode shows status");

   property p_base_gate;
      @(posedge ref_clk) disable iff (sys_rst)
      !loop_active |=> !base_source_eff;
   endproperty
   a_base_gate: assert property (p_base_gate) else $error("vco base clock with loop off");

   property p_centre;
      @(posedge ref_clk) disable iff (sys_rst)
      $stable(linear_l) && $stable(range_e) |=>
      centre_freq_khz == KW'((KW'($past(linear_l)) << $past(range_e)) * cgpl_pkg::NOM_KHZ) &&
      vco_max_khz == KW'(centre_freq_khz << 1) && vco_min_khz == (centre_freq_khz >> 1);
   endproperty
   a_centre: assert property (p_centre) else $error("centre frequency wrong");
endmodule

//--- design/cgpl_mod_div.sv
// modulo divider of single-cycle edge ticks
`timescale 1ns/100ps
module cgpl_mod_div #(
   parameter int W = cgpl_pkg::CNT_W
) (
   input  wire logic   ref_clk,
   input  wire logic   sys_rst,
   input  wire logic   enable,
   cgpl_div_if.div     d
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         tick;
   logic         next_tick;
   logic [W-1:0] last;

   if (W < 1 || W > 16) begin : g_chk
      $error("cgpl_mod_div: width out of range");
   end

   // zero modulus behaves as one
   assign last = (d.modulus == '0) ? '0 : W'(d.modulus - W'(1));

   always_comb begin
      next_count = count;
      next_tick  = 1'b0;
      if (!enable) begin
         next_count = '0;
      end else if (d.in_tick) begin
         if (count >= last) begin
            next_count = '0;
            next_tick  = 1'b1;
         end else begin
            next_count = W'(count + W'(1));
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end

   assign d.out_tick = tick;

   property p_tick_cause;
      @(posedge ref_clk) disable iff (sys_rst)
      d.out_tick |-> $past(d.in_tick) && $past(enable);
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("divider tick without input");
endmodule

//--- design/cgpl_pkg.sv
// constants shared by the loop control block and its dividers
package cgpl_pkg;
   localparam int          CNT_W        = 12;    // modulo divider counter width
   localparam int          REF_DIV_W    = 4;     // reference divide factor width
   localparam int          FB_MOD_W     = 12;    // feedback modulo factor width
   localparam int          LIN_W        = 8;     // vco linear factor width
   localparam int          EXP_W        = 2;     // range exponent and prescaler width
   localparam int          KHZ_W        = 21;    // frequency report width in kHz
   localparam int          NOM_KHZ      = 125;   // nominal base frequency
   localparam int          LOCK_PERIODS = 4;     // matching reference periods to settle
   localparam int          RUN_W        = 4;     // settle run counter width
   localparam logic [KHZ_W-1:0] NOM_KHZ_V = KHZ_W'(NOM_KHZ);
endpackage

//--- testbench/tb_top.sv
// self-checking bench for the loop divider, lock and filter mode control
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [3:0]  sel;
      logic [31:0] val;
   } cgpl_tb_note_t;

   logic                                ref_clk;
   logic                                sys_rst;
   logic                                ref_pin;
   logic                                vco_pin;
   logic                                loop_power_en;
   logic                                auto_bw;
   logic                                tracking_select_wr;
   logic                                settle_change_irq_en_wr;
   logic                                flag_clear;
   logic                                base_source_sel;
   logic [cgpl_pkg::REF_DIV_W-1:0]      ref_div_r;
   logic [cgpl_pkg::FB_MOD_W-1:0]       fb_mod_n;
   logic [cgpl_pkg::EXP_W-1:0]          prescale_p;
   logic [cgpl_pkg::EXP_W-1:0]          range_e;
   logic [cgpl_pkg::LIN_W-1:0]          linear_l;
   logic                                divided_ref_clock;
   logic                                prescaled_vco_clock;
   logic                                feedback_clock;
   logic                                pump_up;
   logic                                pump_dn;
   logic                                filter_tracking;
   logic                                tracking_select;
   logic                                settled;
   logic                                settle_change_flag;
   logic                                settle_change_irq_en;
   logic                                irq;
   logic                                base_source_eff;
   logic [cgpl_pkg::KHZ_W-1:0]          centre_freq_khz;
   logic [cgpl_pkg::KHZ_W-1:0]          vco_min_khz;
   logic [cgpl_pkg::KHZ_W-1:0]          vco_max_khz;
   // start values set here so the pin loops never see a zero half period at time 0
   int                                  ref_half = 4;
   int                                  vco_half = 3;
   logic                                up_seen = 1'b0;
   logic                                dn_seen = 1'b0;
   int                                  ref_edges;
   int                                  vco_edges;
   int                                  miscompares;
   int                                  cmp_count;
   int                                  seed;
   cgpl_tb_note_t                       notes[$];

   cgpl_loop_ctrl #(.LOCK_PERIODS(2)) cgpl_loop_ctrl_inst (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .buffered_ref_clock(ref_pin),
      .vco_clock(vco_pin), .loop_power_en(loop_power_en), .auto_bw(auto_bw),
      .tracking_select_wr(tracking_select_wr),
      .settle_change_irq_en_wr(settle_change_irq_en_wr), .flag_clear(flag_clear),
      .base_source_sel(base_source_sel), .ref_div_r(ref_div_r), .fb_mod_n(fb_mod_n),
      .prescale_p(prescale_p), .range_e(range_e), .linear_l(linear_l),
      .divided_ref_clock(divided_ref_clock), .prescaled_vco_clock(prescaled_vco_clock),
      .feedback_clock(feedback_clock), .pump_up(pump_up), .pump_dn(pump_dn),
      .filter_tracking(filter_tracking), .tracking_select(tracking_select),
      .settled(settled), .settle_change_flag(settle_change_flag),
      .settle_change_irq_en(settle_change_irq_en), .irq(irq),
      .base_source_eff(base_source_eff), .centre_freq_khz(centre_freq_khz),
      .vco_min_khz(vco_min_khz), .vco_max_khz(vco_max_khz));

   // ----------------------------------------
   // clock and pin stimulus
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // pins change on the falling edge; half periods stay >= 3 cycles for the synchronisers
   initial begin
      ref_pin = 1'b0;
      forever begin
         repeat (ref_half) @(negedge ref_clk);
         ref_pin = ~ref_pin;
         if (ref_pin) ref_edges++;
      end
   end
   initial begin
      vco_pin = 1'b0;
      forever begin
         repeat (vco_half) @(negedge ref_clk);
         vco_pin = ~vco_pin;
         if (vco_pin) vco_edges++;
      end
   end

   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   function automatic logic [31:0] obs(input int sel);
      case (sel)
         0: obs = {26'h0, irq, settle_change_irq_en, settle_change_flag, settled,
                   tracking_select, filter_tracking};
         1: obs = 32'(centre_freq_khz);
         2: obs = 32'(vco_min_khz);
         3: obs = 32'(vco_max_khz);
         4: obs = {31'h0, divided_ref_clock};
         5: obs = {31'h0, feedback_clock};
         6: obs = {31'h0, prescaled_vco_clock};
         8: obs = {30'h0, up_seen, dn_seen};
         default: obs = {31'h0, base_source_eff};
      endcase
   endfunction

   function automatic int cnt(input int sel);
      cnt = (sel == 4) ? ref_edges : vco_edges;
   endfunction

   // pin edges between two output toggles; the first toggle is dropped as partial
   task automatic meas(input int sel, output logic [31:0] d);
      logic [31:0] v;
      int          c0;
      int          t;
      d = 32'hFFFFFFFF;
      c0 = 0;
      for (int k = 0; k < 3; k++) begin
         v = obs(sel);
         t = 0;
         while (obs(sel) === v && t < 4000) begin
            @(posedge ref_clk);
            #1;
            t++;
         end
         if (k == 1) c0 = cnt(sel);
         if (k == 2) d = 32'(cnt(sel) - c0);
      end
   endtask

   initial begin
      cgpl_tb_note_t n;
      logic [31:0]   got;
      forever begin
         wait (notes.size() != 0);
         n = notes[0];
         if (n.sel >= 4'h4 && n.sel <= 4'h6) begin
            meas(int'(n.sel), got);
         end else begin
            @(posedge ref_clk);
            #1;
            got = obs(int'(n.sel));
         end
         check(got, n.val);
         void'(notes.pop_front());
      end
   end

   always @(negedge ref_clk) begin
      if (pump_up === 1'b1 && pump_dn === 1'b1) check(32'h1, 32'h0);
      // both pump directions must show up somewhere in the run
      if (pump_up === 1'b1) up_seen = 1'b1;
      if (pump_dn === 1'b1) dn_seen = 1'b1;
   end

   task automatic note_exp(input logic [3:0] sel, input logic [31:0] v);
      notes.push_back('{sel, v});
      wait (notes.size() == 0);
      @(negedge ref_clk);
   endtask

   task automatic step(input int k);
      repeat (k) @(negedge ref_clk);
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // a full run needs at most about 4000 cycles
   initial begin
      #(100 * 40000);
      miscompares++;
      stop_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int l;
      int e;
      int c;
      int r;
      int nn;
      int p;
      seed = 67;
      ref_half = 4;
      vco_half = 3;
      ref_edges = 0;
      vco_edges = 0;
      miscompares = 0;
      cmp_count = 0;
      sys_rst = 1'b1;
      {loop_power_en, auto_bw, tracking_select_wr, settle_change_irq_en_wr} = 4'h0;
      flag_clear = 1'b0;
      base_source_sel = 1'b0;
      ref_div_r = 4'h1;
      fb_mod_n = 12'h001;
      prescale_p = 2'h0;
      range_e = 2'h0;
      linear_l = 8'h40;
      step(3);
      sys_rst = 1'b0;
      note_exp(4'h0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         l = $unsigned($random(seed)) % 255 + 1;
         e = $unsigned($random(seed)) % 3;
         linear_l = 8'(l);
         range_e = 2'(e);
         step(3);
         c = l * (1 << e) * 125;
         note_exp(4'h1, 32'(c));
         note_exp(4'h2, 32'(c >> 1));
         note_exp(4'h3, 32'(c * 2));
      end
      // a zero divide factor must behave as one
      auto_bw = 1'b1;
      linear_l = 8'h40;
      for (int i = 0; i < 4; i++) begin
         r = (i == 0) ? 0 : $unsigned($random(seed)) % 4 + 1;
         nn = (i == 1) ? 0 : $unsigned($random(seed)) % 4 + 1;
         p = $unsigned($random(seed)) % 4;
         loop_power_en = 1'b0;
         ref_div_r = 4'(r);
         fb_mod_n = 12'(nn);
         prescale_p = 2'(p);
         step(2);
         loop_power_en = 1'b1;
         note_exp(4'h4, 32'((r == 0) ? 1 : r));
         note_exp(4'h6, 32'(1 << p));
         note_exp(4'h5, 32'(((nn == 0) ? 1 : nn) * (1 << p)));
      end
      loop_power_en = 1'b0;
      ref_div_r = 4'h1;
      fb_mod_n = 12'h001;
      prescale_p = 2'h0;
      ref_half = 10;
      vco_half = 10;
      settle_change_irq_en_wr = 1'b1;
      step(2);
      loop_power_en = 1'b1;
      step(250);
      note_exp(4'h0, 32'h3F);
      base_source_sel = 1'b1;
      step(3);
      note_exp(4'h7, 32'h1);
      flag_clear = 1'b1;
      step(1);
      flag_clear = 1'b0;
      step(2);
      note_exp(4'h0, 32'h17);
      vco_half = 5;
      step(120);
      note_exp(4'h0, 32'h38);
      settle_change_irq_en_wr = 1'b0;
      step(3);
      note_exp(4'h0, 32'h08);
      linear_l = 8'h00;
      step(3);
      note_exp(4'h7, 32'h0);
      linear_l = 8'h40;
      base_source_sel = 1'b0;
      auto_bw = 1'b0;
      settle_change_irq_en_wr = 1'b1;
      loop_power_en = 1'b0;
      tracking_select_wr = 1'b0;
      step(3);
      note_exp(4'h0, 32'h00);
      // feedback slower than reference here, so the up pulse must appear
      vco_half = 20;
      loop_power_en = 1'b1;
      step(50);
      tracking_select_wr = 1'b1;
      step(3);
      note_exp(4'h0, 32'h03);
      step(50);
      base_source_sel = 1'b1;
      step(3);
      note_exp(4'h7, 32'h1);
      base_source_sel = 1'b0;
      step(2);
      loop_power_en = 1'b0;
      step(3);
      note_exp(4'h0, 32'h00);
      note_exp(4'h8, 32'h3);
      stop_test();
   end
endmodule
